// ===== inc/codec_cmd_pkg.sv
/*
 * constants, command codes, field positions and carrier types of the
 * codec command register bank.
 * assumes a byte-level command stream from the serial interface logic.
 */
package codec_cmd_pkg;

	// ---------------------------------------------------------------
	// command codes (bit 0 selects read)
	// ---------------------------------------------------------------
	localparam logic [7:0] cmd_mask_wr = 8'h6c;
	localparam logic [7:0] cmd_mask_rd = 8'h6d;
	localparam logic [7:0] cmd_opcond_wr = 8'h70;
	localparam logic [7:0] cmd_opcond_rd = 8'h71;
	localparam logic [7:0] cmd_revision_rd = 8'h73;
	localparam logic [7:0] cmd_gain_wr = 8'h80;
	localparam logic [7:0] cmd_gain_rd = 8'h81;
	localparam int rw_bit = 0;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] mask_reset = 8'hff;
	localparam logic [7:0] opcond_reset = 8'h00;
	localparam logic [15:0] gain_default = 16'ha9f0;
	// arbitrary revision value
	localparam logic [7:0] revision_value = 8'h01;

	// ---------------------------------------------------------------
	// operating conditions field positions
	// ---------------------------------------------------------------
	localparam int oc_tx_cutoff = 7;
	localparam int oc_rx_cutoff = 6;
	localparam int oc_hp_bypass = 5;
	localparam int oc_rx_loss = 4;
	localparam int oc_tx_arm = 3;
	localparam int oc_slot_lb = 2;
	localparam int oc_full_lb = 1;
	localparam int oc_tone = 0;

	// ---------------------------------------------------------------
	// carrier types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic tx_path_cutoff;
		logic rx_path_cutoff;
		logic highpass_bypass;
		logic rx_extra_loss;
		logic tx_interrupt_arm;
		logic slot_loopback_enable;
		logic full_digital_loopback;
		logic rx_test_tone;
	} opcond_t;

	typedef struct packed {
		logic sign;
		logic [2:0] shift;
	} gain_term_t;

	// byte 1: fourth, third pair; byte 2: second, first pair
	typedef struct packed {
		gain_term_t fourth;
		gain_term_t third;
		gain_term_t second;
		gain_term_t first;
	} gain_coef_t;

	typedef enum logic [2:0] {
		st_command = 3'b001,
		st_data1 = 3'b010,
		st_data2 = 3'b100
	} cmd_state_t;

endpackage : codec_cmd_pkg

// ===== rtl/codec_control_command_regs.sv
/*
 * command register bank: detect interrupt mask, operating conditions,
 * revision code and programmable transmit gain coefficient.
 * assumes the serial interface delivers whole bytes on mclk as one-cycle
 * strobes, the byte strobed together with frame_start being the command byte, and
 * that the open-drain interrupt wire is resolved outside from int_oe.
 */
// Summary of operation
// - mask written by 6C, read by 6D, one data byte follows.
// - mask bit 7 is channel 4 input B down to bit 0 channel 1 A.
// - masked detect changes never pull interrupt low; unmasked ones do.
// - reset loads mask with all ones.
// - mask access ignores the per-channel enable selection.
// - operating conditions written by 70, read by 71, one data byte.
// - highpass bypass one removes transmit highpass, zero keeps it.
// - receive loss one inserts 6 dB receive attenuation.
// - transmit interrupt arm enables transmit interrupt, reset zero.
// - command 73 returns fixed 8-bit revision, read only.
// - gain coefficient by 80/81, two bytes, fourth/third then second/first.
// - gain is one plus nested sign-shift product through fourth pair.
// - fixed default coefficient kept apart; select input picks programmed.
`timescale 1ns/1ps
module codec_control_command_regs
	import codec_cmd_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// command byte stream
	input wire logic frame_start,
	input wire logic byte_strobe,
	input wire logic [7:0] byte_in,
	output logic [7:0] read_byte,
	output logic read_valid,
	// detect inputs and interrupt
	input wire logic [7:0] detect_input_bit,
	input wire logic int_clear,
	input wire logic tx_event,
	output logic int_o,
	output logic int_oe,
	// configuration to the datapath
	input wire logic tx_gain_programmed_select,
	output opcond_t opcond,
	output gain_coef_t tx_gain_coef
);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0] detect_interrupt_mask;
	logic [7:0] operating_conditions;
	logic [15:0] transmit_gain_coefficient;
	cmd_state_t state;
	logic [7:0] command;

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	function automatic logic is_known(input logic [7:0] c);
		is_known = (c == cmd_mask_wr) || (c == cmd_mask_rd) ||
			(c == cmd_opcond_wr) || (c == cmd_opcond_rd) ||
			(c == cmd_revision_rd) || (c == cmd_gain_wr) ||
			(c == cmd_gain_rd);
	endfunction : is_known

	wire cmd_take = byte_strobe && (frame_start || state == st_command);
	wire data_take = byte_strobe && !frame_start && state != st_command;
	wire is_write = !command[rw_bit];
	wire hit_mask = command[7:1] == cmd_mask_wr[7:1];
	wire hit_opcond = command[7:1] == cmd_opcond_wr[7:1];
	wire hit_gain = command[7:1] == cmd_gain_wr[7:1];
	wire wr_mask = data_take && is_write && hit_mask;
	wire wr_opcond = data_take && is_write && hit_opcond;
	// byte 1 high, byte 2 low
	wire wr_gain_hi = data_take && is_write && hit_gain &&
		state == st_data1;
	wire wr_gain_lo = data_take && is_write && hit_gain &&
		state == st_data2;

	// ---------------------------------------------------------------
	// command sequencer
	// ---------------------------------------------------------------
	cmd_state_t next_state;
	always_comb
	begin
		next_state = state;
		if (cmd_take)
			next_state = is_known(byte_in) ? st_data1 : st_command;
		else if (data_take)
		begin
			unique case (state)
				st_data1: next_state = hit_gain ? st_data2 : st_command;
				st_data2: next_state = st_command;
				default: next_state = st_command;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state <= st_command;
			command <= 8'h00;
		end
		else
		begin
			state <= next_state;
			if (cmd_take)
				command <= byte_in;
		end
	end

	// ---------------------------------------------------------------
	// register writes
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			detect_interrupt_mask <= mask_reset;
			operating_conditions <= opcond_reset;
			transmit_gain_coefficient <= gain_default;
		end
		else
		begin
			if (wr_mask)
				detect_interrupt_mask <= byte_in;
			if (wr_opcond)
				operating_conditions <= byte_in;
			if (wr_gain_hi)
				transmit_gain_coefficient[15:8] <= byte_in;
			if (wr_gain_lo)
				transmit_gain_coefficient[7:0] <= byte_in;
		end
	end

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	// revision read only, no write form
	wire [7:0] rd_first =
		(byte_in == cmd_mask_rd) ? detect_interrupt_mask :
		(byte_in == cmd_opcond_rd) ? operating_conditions :
		(byte_in == cmd_revision_rd) ? revision_value :
		(byte_in == cmd_gain_rd) ? transmit_gain_coefficient[15:8] :
		8'h00;
	wire rd_cmd = cmd_take && is_known(byte_in) && byte_in[rw_bit];
	wire rd_second = data_take && state == st_data1 &&
		command == cmd_gain_rd;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			read_byte <= 8'h00;
			read_valid <= 1'b0;
		end
		else
		begin
			read_valid <= rd_cmd || rd_second;
			if (rd_cmd)
				read_byte <= rd_first;
			else if (rd_second)
				read_byte <= transmit_gain_coefficient[7:0];
		end
	end

	// ---------------------------------------------------------------
	// detect change interrupt
	// ---------------------------------------------------------------
	logic [7:0] det_meta;
	logic [7:0] det_sync;
	logic [7:0] det_last;
	logic pending;
	logic tx_pending;

	// bit i of mask gates bit i of detect
	wire [7:0] det_change = det_sync ^ det_last;
	wire det_event = |(det_change & ~detect_interrupt_mask);
	wire tx_hit = tx_event && operating_conditions[oc_tx_arm];

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			det_meta <= 8'h00;
			det_sync <= 8'h00;
			det_last <= 8'h00;
			pending <= 1'b0;
			tx_pending <= 1'b0;
		end
		else
		begin
			det_meta <= detect_input_bit;
			det_sync <= det_meta;
			det_last <= det_sync;
			// set wins over clear
			pending <= det_event || (pending && !int_clear);
			tx_pending <= tx_hit || (tx_pending && !int_clear);
		end
	end

	assign int_o = 1'b0;
	assign int_oe = pending || tx_pending;

	// ---------------------------------------------------------------
	// configuration outputs
	// ---------------------------------------------------------------
	// highpass bypass to datapath
	// 6 dB receive loss to datapath
	assign opcond = opcond_t'(operating_conditions);
	// sign/shift pairs for the nested gain product
	// default held apart, select picks programmed
	assign tx_gain_coef = tx_gain_programmed_select ?
		gain_coef_t'(transmit_gain_coefficient) : gain_coef_t'(gain_default);

endmodule : codec_control_command_regs

// ===== tb/codec_cmd_properties.sv
/* port checker of the command register bank.
   assumes it is bound to codec_control_command_regs. */
`timescale 1ns/1ps
module codec_cmd_checker
	import codec_cmd_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// command stream
	input wire logic frame_start,
	input wire logic byte_strobe,
	input wire logic [7:0] byte_in,
	input wire logic [7:0] read_byte,
	input wire logic read_valid,
	// interrupt and datapath
	input wire logic tx_event,
	input wire logic int_o,
	input wire logic int_oe,
	input wire logic tx_gain_programmed_select,
	input wire opcond_t opcond,
	input wire gain_coef_t tx_gain_coef
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence s_cmd(logic [7:0] c);
		byte_strobe && frame_start && byte_in == c;
	endsequence
	sequence s_oc_wr;
		s_cmd(cmd_opcond_wr) ##1 !byte_strobe ##1 byte_strobe && !frame_start;
	endsequence
	property p_rev;
		s_cmd(cmd_revision_rd) |=> read_valid && read_byte == revision_value;
	endproperty
	a_rev: assert property (p_rev) else $error("bad revision");
	property p_mask_rd;
		s_cmd(cmd_mask_rd) |=> read_valid;
	endproperty
	a_mask_rd: assert property (p_mask_rd) else $error("no mask read");
	property p_unknown;
		s_cmd(8'h72) |=> !read_valid;
	endproperty
	a_unknown: assert property (p_unknown) else $error("bad answer");
	property p_oc_wr;
		s_oc_wr |=> opcond == $past(byte_in);
	endproperty
	a_oc_wr: assert property (p_oc_wr) else $error("opcond write");
	property p_gain_rd;
		s_cmd(cmd_gain_rd) ##1 tx_gain_programmed_select
			|-> read_valid && read_byte == tx_gain_coef[15:8];
	endproperty
	a_gain_rd: assert property (p_gain_rd) else $error("gain read");
	property p_gain_sel;
		!tx_gain_programmed_select |-> tx_gain_coef == gain_default;
	endproperty
	a_gain_sel: assert property (p_gain_sel) else $error("gain mux");
	property p_rst;
		$fell(rst) |-> opcond == opcond_reset && !read_valid;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values");
	property p_int_o;
		int_o == 1'b0;
	endproperty
	a_int_o: assert property (p_int_o) else $error("pin drive");
	property p_tx_arm;
		tx_event && opcond.tx_interrupt_arm |=> int_oe;
	endproperty
	a_tx_arm: assert property (p_tx_arm) else $error("tx interrupt");
endmodule : codec_cmd_checker
bind codec_control_command_regs codec_cmd_checker chk_u (.mclk(mclk),
	.rst(rst), .frame_start(frame_start), .byte_strobe(byte_strobe),
	.byte_in(byte_in), .read_byte(read_byte), .read_valid(read_valid),
	.tx_event(tx_event), .int_o(int_o), .int_oe(int_oe),
	.tx_gain_programmed_select(tx_gain_programmed_select),
	.opcond(opcond), .tx_gain_coef(tx_gain_coef));

// ===== tb/host_model.sv
/* host processor model issuing command and data bytes.
   assumes one byte per strobe on mclk. */
`timescale 1ns/1ps
module host_model (
	// clock
	input wire logic mclk,
	// command stream
	output logic frame_start,
	output logic byte_strobe,
	output logic [7:0] byte_in
);
	initial
	begin
		frame_start = 0;
		byte_strobe = 0;
		byte_in = 0;
	end
	task put(input logic [7:0] b, input logic f);
		@(posedge mclk);
		#1;
		byte_strobe = 1;
		frame_start = f;
		byte_in = b;
		@(posedge mclk);
		#1;
		byte_strobe = 0;
		frame_start = 0;
		byte_in = ~b;
	endtask : put
endmodule : host_model

// ===== tb/testbench.sv
/* self-checking bench of the command register bank.
   assumes host_model and the bound port checker. */
`timescale 1ns/1ps
module testbench;
	import codec_cmd_pkg::*;
	logic mclk = 0, rst = 1, sel = 0, clr = 0, txe = 0;
	logic [7:0] det = 0;
	wire fs, bs, rv, ioe, io;
	wire [7:0] bi, rdb;
	opcond_t oc;
	gain_coef_t gc;
	int n_mismatch = 0, num_checks = 0, cyc = 0, k;
	int mask = 255, ocv = 0, gain = 'ha9f0;
	integer seed = 32'h6a53d8b4;
	host_model host_u (.mclk(mclk), .frame_start(fs), .byte_strobe(bs),
		.byte_in(bi));
	codec_control_command_regs dut_u (.mclk(mclk), .rst(rst),
		.frame_start(fs), .byte_strobe(bs), .byte_in(bi), .read_byte(rdb),
		.read_valid(rv), .detect_input_bit(det), .int_clear(clr),
		.tx_event(txe), .int_o(io), .int_oe(ioe),
		.tx_gain_programmed_select(sel), .opcond(oc), .tx_gain_coef(gc));
	initial
		forever #4 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end
	task tick;
		@(posedge mclk);
		#1;
	endtask : tick
	task chk(input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task rd(input logic [7:0] c, input logic f, input int e);
		host_u.put(c, f);
		chk(rv, 1);
		chk(rdb, e[7:0]);
	endtask : rd
	task wr(input logic [7:0] c, input int d);
		host_u.put(c, 1);
		host_u.put(d[7:0], 0);
	endtask : wr
	task clear_int;
		clr = 1;
		tick();
		clr = 0;
		tick();
		chk(ioe, 0);
	endtask : clear_int
	task intr(input int b, input logic e);
		det[b] = ~det[b];
		repeat (6) tick();
		chk(ioe, e);
		chk(io, 0);
		clear_int();
	endtask : intr
	task tx_pulse(input logic e);
		txe = 1;
		tick();
		txe = 0;
		chk(ioe, e);
		clear_int();
	endtask : tx_pulse
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	initial
	begin
		repeat (16) tick();
		rst = 0;
		rd(cmd_mask_rd, 1, mask);
		rd(cmd_opcond_rd, 1, ocv);
		rd(cmd_revision_rd, 1, revision_value);
		host_u.put(8'h72, 1);
		chk(rv, 0);
		intr(0, 0);
		repeat (4)
		begin
			mask = $random(seed) & 255;
			wr(cmd_mask_wr, mask);
			rd(cmd_mask_rd, 1, mask);
			k = $unsigned($random(seed)) % 8;
			intr(k, !mask[k]);
		end
		for (k = 0; k < 9; k++)
		begin
			ocv = k < 8 ? 1 << k : $random(seed) & 255;
			wr(cmd_opcond_wr, ocv);
			chk(oc, ocv);
			rd(cmd_opcond_rd, 1, ocv);
		end
		wr(cmd_opcond_wr, 8);
		tx_pulse(1);
		wr(cmd_opcond_wr, 0);
		tx_pulse(0);
		gain = $random(seed) & 16'hffff;
		host_u.put(cmd_gain_wr, 1);
		host_u.put(gain[15:8], 0);
		host_u.put(gain[7:0], 0);
		sel = 1;
		tick();
		chk(gc, gain);
		rd(cmd_gain_rd, 1, gain[15:8]);
		rd(8'h00, 0, gain[7:0]);
		sel = 0;
		tick();
		chk(gc, gain_default);
		// lone first gain byte, then a new command aborts the sequence
		k = $random(seed) & 255;
		host_u.put(cmd_gain_wr, 1);
		host_u.put(k[7:0], 0);
		gain = (gain & 255) | (k << 8);
		sel = 1;
		rd(cmd_mask_rd, 1, mask);
		chk(gc, gain);
		// reset in mid-run
		rst = 1;
		tick();
		rst = 0;
		chk(gc, gain_default);
		rd(cmd_mask_rd, 1, 255);
		rd(cmd_opcond_rd, 1, 0);
		chk(oc, 0);
		end_of_test();
	end
endmodule : testbench
